// ==== logic/cfc_defines.svh ====
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH

// register byte addresses on the bus
`define CFC_CTRL_ADDR 32'hFFFFFE90
`define CFC_STAT_ADDR 32'hFFFFFE94

// control register field positions
`define CFC_PLL2_BIT 7
`define CFC_PLL1_BIT 6
`define CFC_FLOAT_BIT 5
`define CFC_RSV_BIT 4
`define CFC_RATIO_MSB 3
`define CFC_RATIO_LSB 0

// control register value after power-on, per clock mode
`define CFC_RST_MODE0 8'h00
`define CFC_RST_MODE1 8'h00
`define CFC_RST_MODE2 8'h40
`define CFC_RST_MODE3 8'h60
`define CFC_RST_MODE4 8'hA6
`define CFC_RST_MODE5 8'hA6
`define CFC_RST_MODE6 8'hE0

// cycles after reset release before the mode pins are trusted
`define CFC_INIT_CYCLES 3'h4

// ratios are carried in quarters of the input clock
`define CFC_Q4 5'h10
`define CFC_Q2 5'h08
`define CFC_Q1 5'h04
`define CFC_QH 5'h02
`define CFC_QQ 5'h01

`endif

// ==== logic/cfc_pkg.sv ====
package cfc_pkg;

    typedef enum logic [2:0] {
        CFC_ST_INIT = 3'b001,
        CFC_ST_RUN = 3'b010,
        CFC_ST_SETTLE = 3'b100
    } cfc_state_e;

    typedef struct packed {
        logic second_pll_halt;
        logic first_pll_halt;
        logic clock_pin_float;
        logic reserved;
        logic [3:0] clock_ratio_field;
    } cfc_ctrl_s;

    // each ratio in quarters of the input clock, zero when illegal
    typedef struct packed {
        logic [4:0] base;
        logic [4:0] core;
        logic [4:0] bus;
        logic [4:0] per;
    } cfc_ratio_s;

endpackage

// ==== logic/cfc_ctrl.sv ====
`timescale 1ns/1ns
`include "cfc_defines.svh"

// Operation
// - bit 7 halts second pll; writable modes 0-3, reads 1 in modes 4-6
// - bit 6 halts first pll; writable modes 0,1,4,5, reads 1 otherwise
// - bit 5 floats clock pin in modes 0-3; pin is input and bit reads 1 else
// - bit 4 reserved, reads 0, software writes 0
// - both plls running, modes 0/1: base x4, nine ratio codes, pin gives bus clock
// - first pll halted, second running, modes 0-3: five ratio codes
// - only first pll running, modes 0/1: base x4, three ratio codes
// - modes 4/5, first pll running: base x2, four ratio codes
// - both plls halted: base x1, ten fractional ratio codes, pin equals input
// - control write stops internal clocks and starts the watchdog count
// - settling overflow applies new frequency with no overflow side effects
// - sequence not observed: no watchdog start, pll not operational
// - clock pin may be unstable while the pll settles
// - control register reset only by power-on reset, not watchdog reset
// - control reset value follows the clock mode pins
module cfc_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic [2:0] clock_mode_pins_i,
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe_o,
    input wire logic bus_clk_lvl_i,
    input wire logic watchdog_timer_mode_i,
    input wire logic watchdog_count_enable_i,
    input wire logic cache_read_i,
    input wire logic ext_write_i,
    input wire logic dma_busy_i,
    input wire logic watchdog_overflow_i,
    output logic watchdog_start_o,
    output logic clocks_stop_o,
    output logic overflow_suppress_o,
    output logic freq_apply_o,
    output logic pin_stable_o,
    output logic second_pll_halt_o,
    output logic first_pll_halt_o,
    output cfc_pkg::cfc_ratio_s ratio_o
);

    // force the bits a mode does not allow software to change
    function automatic cfc_pkg::cfc_ctrl_s fix_bits(input logic [2:0] mode, input cfc_pkg::cfc_ctrl_s v);
        cfc_pkg::cfc_ctrl_s r;
        r = v;
        r.reserved = 1'b0;
        if (mode[2]) begin
            r.second_pll_halt = 1'b1;
            r.clock_pin_float = 1'b1;
        end
        if (mode == 3'h2 || mode == 3'h3 || mode[2:1] == 2'b11) begin
            r.first_pll_halt = 1'b1;
        end
        return r;
    endfunction

    // quarter-unit ratio set; all zero marks a forbidden code
    function automatic cfc_pkg::cfc_ratio_s decode(input logic [2:0] mode, input cfc_pkg::cfc_ctrl_s v);
        cfc_pkg::cfc_ratio_s r;
        r = '0;
        unique case ({v.first_pll_halt, v.second_pll_halt})
            2'b00: begin
                r.base = `CFC_Q4;
                unique case (v.clock_ratio_field)
                    4'h0: r[14:0] = {`CFC_Q1, `CFC_Q1, `CFC_Q1};
                    4'h4: r[14:0] = {`CFC_Q2, `CFC_Q1, `CFC_Q1};
                    4'h5: r[14:0] = {`CFC_Q2, `CFC_Q2, `CFC_Q1};
                    4'h6: r[14:0] = {`CFC_Q2, `CFC_Q2, `CFC_Q2};
                    4'h8: r[14:0] = {`CFC_Q4, `CFC_Q1, `CFC_Q1};
                    4'h9: r[14:0] = {`CFC_Q4, `CFC_Q2, `CFC_Q1};
                    4'hA: r[14:0] = {`CFC_Q4, `CFC_Q2, `CFC_Q2};
                    4'hC: r[14:0] = {`CFC_Q4, `CFC_Q4, `CFC_Q1};
                    4'hE: r[14:0] = {`CFC_Q4, `CFC_Q4, `CFC_Q2};
                    default: r = '0;
                endcase
            end
            2'b10: begin
                unique case (v.clock_ratio_field)
                    4'h0: r = {`CFC_Q1, `CFC_Q1, `CFC_Q1, `CFC_Q1};
                    4'h5: r = {`CFC_Q2, `CFC_Q2, `CFC_Q2, `CFC_Q1};
                    4'h6: r = {`CFC_Q2, `CFC_Q2, `CFC_Q2, `CFC_Q2};
                    4'hC: r = {`CFC_Q4, `CFC_Q4, `CFC_Q4, `CFC_Q1};
                    4'hE: r = {`CFC_Q4, `CFC_Q4, `CFC_Q4, `CFC_Q2};
                    default: r = '0;
                endcase
            end
            2'b01: begin
                if (!mode[2]) begin
                    unique case (v.clock_ratio_field)
                        4'h0: r = {`CFC_Q4, `CFC_Q1, `CFC_Q1, `CFC_Q1};
                        4'h4: r = {`CFC_Q4, `CFC_Q2, `CFC_Q1, `CFC_Q1};
                        4'h8: r = {`CFC_Q4, `CFC_Q4, `CFC_Q1, `CFC_Q1};
                        default: r = '0;
                    endcase
                end else begin
                    unique case (v.clock_ratio_field)
                        4'h5: r = {`CFC_Q2, `CFC_Q1, `CFC_Q1, `CFC_QH};
                        4'h6: r = {`CFC_Q2, `CFC_Q1, `CFC_Q1, `CFC_Q1};
                        4'h9: r = {`CFC_Q2, `CFC_Q2, `CFC_Q1, `CFC_QH};
                        4'hA: r = {`CFC_Q2, `CFC_Q2, `CFC_Q1, `CFC_Q1};
                        default: r = '0;
                    endcase
                end
            end
            2'b11: begin
                r.base = `CFC_Q1;
                unique case (v.clock_ratio_field)
                    4'h0: r[14:0] = {`CFC_QQ, `CFC_QQ, `CFC_QQ};
                    4'h4: r[14:0] = {`CFC_QH, `CFC_QQ, `CFC_QQ};
                    4'h5: r[14:0] = {`CFC_QH, `CFC_QH, `CFC_QQ};
                    4'h6: r[14:0] = {`CFC_QH, `CFC_QH, `CFC_QH};
                    4'h8: r[14:0] = {`CFC_Q1, `CFC_QQ, `CFC_QQ};
                    4'h9: r[14:0] = {`CFC_Q1, `CFC_QH, `CFC_QQ};
                    4'hA: r[14:0] = {`CFC_Q1, `CFC_QH, `CFC_QH};
                    4'hC: r[14:0] = {`CFC_Q1, `CFC_Q1, `CFC_QQ};
                    4'hE: r[14:0] = {`CFC_Q1, `CFC_Q1, `CFC_QH};
                    4'hF: r[14:0] = {`CFC_Q1, `CFC_Q1, `CFC_Q1};
                    default: r = '0;
                endcase
            end
        endcase
        return r;
    endfunction

    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_st_r;
    logic [2:0] mode;
    logic [2:0] init_cnt_r;
    cfc_pkg::cfc_state_e state_r;
    cfc_pkg::cfc_ctrl_s ctrl_r;
    cfc_pkg::cfc_ctrl_s applied_r;
    cfc_pkg::cfc_ctrl_s rst_val;
    logic armed_r;
    logic violation_r;
    logic [31:0] prdata_r;
    logic hit_ctrl;
    logic hit_stat;
    logic ctrl_wr;
    logic prep_ok;
    logic ratio_bad;

    // mode pins and clock pin come from outside: three stages, accept on agreement
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            pin_st_r <= 4'h0;
        end else begin
            pin_s1_r <= {clock_pin_i, clock_mode_pins_i};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            for (int i = 0; i < 4; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_st_r[i] <= pin_s3_r[i];
                end
            end
        end
    end

    assign mode = pin_st_r[2:0];

    // reset value per mode; modes 1 and 5 share their neighbour's value
    always_comb begin
        unique case (mode)
            3'h0: rst_val = `CFC_RST_MODE0;
            3'h1: rst_val = `CFC_RST_MODE1;
            3'h2: rst_val = `CFC_RST_MODE2;
            3'h3: rst_val = `CFC_RST_MODE3;
            3'h4: rst_val = `CFC_RST_MODE4;
            3'h5: rst_val = `CFC_RST_MODE5;
            default: rst_val = `CFC_RST_MODE6;
        endcase
    end

    // bus decode; pready held low until the strapped value is loaded
    assign hit_ctrl = (paddr_i == `CFC_CTRL_ADDR);
    assign hit_stat = (paddr_i == `CFC_STAT_ADDR);
    assign pready_o = (state_r != cfc_pkg::CFC_ST_INIT);
    assign pslverr_o = psel_i && penable_i && pready_o && !hit_ctrl && !hit_stat;
    assign ctrl_wr = psel_i && penable_i && pready_o && pwrite_i && hit_ctrl;
    // dma must be quiet too, otherwise the change is treated as unprepared
    assign prep_ok = armed_r && !watchdog_timer_mode_i && !watchdog_count_enable_i && !dma_busy_i;

    // strap load after release, then run / settle sequence
    // only the power-on reset pin clears this; a watchdog reset never reaches it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= cfc_pkg::CFC_ST_INIT;
            init_cnt_r <= 3'h0;
            ctrl_r <= '0;
            applied_r <= '0;
            violation_r <= 1'b0;
        end else begin
            unique case (state_r)
                cfc_pkg::CFC_ST_INIT: begin
                    init_cnt_r <= init_cnt_r + 3'h1;
                    if (init_cnt_r == `CFC_INIT_CYCLES) begin
                        ctrl_r <= fix_bits(mode, rst_val);
                        applied_r <= fix_bits(mode, rst_val);
                        state_r <= cfc_pkg::CFC_ST_RUN;
                    end
                end
                cfc_pkg::CFC_ST_RUN: begin
                    if (ctrl_wr) begin
                        ctrl_r <= fix_bits(mode, pwdata_i[7:0]);
                        violation_r <= !prep_ok;
                        if (prep_ok) begin
                            state_r <= cfc_pkg::CFC_ST_SETTLE;
                        end
                    end
                end
                cfc_pkg::CFC_ST_SETTLE: begin
                    if (watchdog_overflow_i) begin
                        applied_r <= ctrl_r;
                        state_r <= cfc_pkg::CFC_ST_RUN;
                    end
                end
            endcase
        end
    end

    // cache-through read arms a change; an external write in between disarms it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_r <= 1'b0;
        end else if (cache_read_i) begin
            armed_r <= 1'b1; // set wins over clear
        end else if (ext_write_i || ctrl_wr) begin
            armed_r <= 1'b0;
        end
    end

    // one-cycle pulses toward the watchdog and clock generator
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            watchdog_start_o <= 1'b0;
            freq_apply_o <= 1'b0;
        end else begin
            watchdog_start_o <= ctrl_wr && prep_ok && state_r == cfc_pkg::CFC_ST_RUN;
            freq_apply_o <= watchdog_overflow_i && state_r == cfc_pkg::CFC_ST_SETTLE;
        end
    end

    // during settling clocks stop and the overflow must not act as a normal one
    assign clocks_stop_o = (state_r == cfc_pkg::CFC_ST_SETTLE);
    assign overflow_suppress_o = (state_r == cfc_pkg::CFC_ST_SETTLE);
    assign ratio_bad = (decode(mode, applied_r) == '0);

    // applied clock selection and pin drive, all registered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_o <= '0;
            second_pll_halt_o <= 1'b1;
            first_pll_halt_o <= 1'b1;
            clock_pin_o <= 1'b0;
            clock_pin_oe_o <= 1'b0;
            pin_stable_o <= 1'b0;
        end else begin
            ratio_o <= decode(mode, applied_r);
            second_pll_halt_o <= applied_r.second_pll_halt;
            first_pll_halt_o <= applied_r.first_pll_halt;
            clock_pin_o <= bus_clk_lvl_i;
            // modes 4-6 take the clock in on this pin, so never drive it there
            clock_pin_oe_o <= !mode[2] && !applied_r.clock_pin_float && state_r != cfc_pkg::CFC_ST_INIT;
            pin_stable_o <= (state_r == cfc_pkg::CFC_ST_RUN);
        end
    end

    // read data is prepared in the setup cycle, ready for the access phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_r <= 32'h00000000;
        end else if (psel_i && !penable_i) begin
            if (hit_ctrl) begin
                prdata_r <= {24'h000000, ctrl_r};
            end else if (hit_stat) begin
                prdata_r <= {16'h0000, applied_r, pin_st_r[3], mode, ratio_bad, violation_r,
                             armed_r, clocks_stop_o};
            end else begin
                prdata_r <= 32'h00000000;
            end
        end
    end

    assign prdata_o = prdata_r;

endmodule

// ==== bench/cfc_ctrl_assertions.sv ====
`timescale 1ns/1ns
`include "cfc_defines.svh"

module cfc_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic [2:0] clock_mode_pins_i,
    input wire logic dma_busy_i,
    input wire logic watchdog_timer_mode_i,
    input wire logic watchdog_overflow_i,
    input wire logic watchdog_start_o,
    input wire logic clocks_stop_o,
    input wire logic overflow_suppress_o,
    input wire logic freq_apply_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // completed transfers to the control register
    logic done_w;
    logic done_r;
    assign done_w = psel_i && penable_i && pready_o && pwrite_i && paddr_i == `CFC_CTRL_ADDR;
    assign done_r = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == `CFC_CTRL_ADDR;
    // overflow ends settling, then the new clock is announced
    sequence s_ovf;
        clocks_stop_o && watchdog_overflow_i;
    endsequence
    sequence s_applied;
        !clocks_stop_o ##[0:1] freq_apply_o;
    endsequence
    AST_START_CAUSE: assert property (watchdog_start_o |-> $past(done_w) && !$past(dma_busy_i))
        else $error("watchdog start without a prepared write");
    AST_SUPP_START: assert property (watchdog_start_o |-> clocks_stop_o && overflow_suppress_o)
        else $error("settling not entered when the watchdog was started");
    AST_NO_PREP: assert property (done_w && (dma_busy_i || watchdog_timer_mode_i) |=> !watchdog_start_o)
        else $error("watchdog started on an unprepared write");
    AST_SUPPRESS: assert property (overflow_suppress_o == clocks_stop_o)
        else $error("overflow side effects not suppressed while settling");
    AST_SETTLE_END: assert property (s_ovf |=> s_applied)
        else $error("new frequency not applied after overflow");
    AST_STOP_HOLD: assert property (clocks_stop_o && !watchdog_overflow_i |=> clocks_stop_o)
        else $error("clocks restarted before overflow");
    AST_RSV_READ: assert property (done_r |-> prdata_o[4] == 1'b0)
        else $error("reserved bit read as one");
    AST_FIXED_HI: assert property (done_r && clock_mode_pins_i[2] |-> prdata_o[7] && prdata_o[5])
        else $error("fixed bits not one in pin-clocked modes");
    AST_PLL1_FIXED: assert property (done_r && clock_mode_pins_i[1] |-> prdata_o[6])
        else $error("first pll bit not fixed");
endmodule

bind cfc_ctrl cfc_ctrl_checker i_chk (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o,
    .clock_mode_pins_i, .dma_busy_i, .watchdog_timer_mode_i, .watchdog_overflow_i,
    .watchdog_start_o, .clocks_stop_o, .overflow_suppress_o, .freq_apply_o
);

// ==== bench/test_clock_frequency_control.sv ====
`timescale 1ns/1ns
`include "cfc_defines.svh"

module test_clock_frequency_control;
    logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [31:0] paddr_i, pwdata_i, prdata_o, rdv;
    logic [2:0] clock_mode_pins_i;
    logic clock_pin_i, clock_pin_o, clock_pin_oe_o, bus_clk_lvl_i, erv;
    logic watchdog_timer_mode_i, watchdog_count_enable_i, cache_read_i, ext_write_i, dma_busy_i;
    logic watchdog_overflow_i, watchdog_start_o, clocks_stop_o, overflow_suppress_o;
    logic freq_apply_o, pin_stable_o, second_pll_halt_o, first_pll_halt_o;
    cfc_pkg::cfc_ratio_s ratio_o;
    int err_count, check_count, seed;

    cfc_ctrl i_dut (
        .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
        .prdata_o, .pslverr_o, .clock_mode_pins_i, .clock_pin_i, .clock_pin_o, .clock_pin_oe_o,
        .bus_clk_lvl_i, .watchdog_timer_mode_i, .watchdog_count_enable_i, .cache_read_i,
        .ext_write_i, .dma_busy_i, .watchdog_overflow_i, .watchdog_start_o, .clocks_stop_o,
        .overflow_suppress_o, .freq_apply_o, .pin_stable_o, .second_pll_halt_o,
        .first_pll_halt_o, .ratio_o
    );

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // bus clock level and pin level keep moving
    always @(posedge clk_i) begin
        bus_clk_lvl_i <= ~bus_clk_lvl_i;
        clock_pin_i <= ~clock_pin_i;
    end

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        err_count++;
        $display("ERROR %0t wait ran out", $time);
        results();
    endtask

    // model of the register: fixed bits per mode, reserved bit zero
    function automatic logic [7:0] fixv(input int m, input logic [7:0] w);
        fixv = w & 8'hEF;
        if (m >= 4) fixv = fixv | 8'hA0;
        if (m == 2 || m == 3 || m >= 6) fixv = fixv | 8'h40;
    endfunction

    function automatic logic [7:0] rstv(input int m);
        logic [7:0] t [8] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'hA6, 8'hA6, 8'hE0, 8'hE0};
        rstv = t[m];
    endfunction

    // pick a ratio code that is listed for the mode and the run/halt state
    function automatic logic [3:0] legal(input int m, input logic [7:0] w);
        logic [7:0] f;
        f = fixv(m, w);
        if (!f[6] && f[7] && m >= 4) legal = {w[3], ~w[3], w[1], ~w[1]};
        else if (!f[6] && f[7]) legal = {w[3], ~w[3] & w[2], 2'b00};
        else if (w[3] | w[2]) legal = {w[3], 1'b1, w[1], ~w[1] & ~w[3]};
        else legal = 4'h0;
    endfunction

    // mode pins only change while reset is held
    task automatic rst(input int m);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        clock_mode_pins_i <= m[2:0];
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) tmo();
        rdv = prdata_o;
        erv = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic arm();
        @(posedge clk_i);
        cache_read_i <= 1'b1;
        @(posedge clk_i);
        cache_read_i <= 1'b0;
    endtask

    // prepared change, overflow, then the applied ratios
    task automatic settle(input int m, input logic [7:0] v, input logic [19:0] e);
        int n;
        rst(m);
        arm();
        apb(1'b1, `CFC_CTRL_ADDR, {24'h0, v});
        #1;
        chk({watchdog_start_o, clocks_stop_o, overflow_suppress_o}, 3'b111);
        repeat (3) @(posedge clk_i);
        #1;
        chk({clocks_stop_o, pin_stable_o, freq_apply_o}, 3'b100);
        @(posedge clk_i);
        watchdog_overflow_i <= 1'b1;
        @(posedge clk_i);
        watchdog_overflow_i <= 1'b0;
        n = 0;
        #1;
        while (freq_apply_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 8) tmo();
        @(posedge clk_i);
        #1;
        chk(ratio_o, e);
        chk({second_pll_halt_o, first_pll_halt_o, clocks_stop_o, pin_stable_o}, {v[7:6], 2'b01});
        chk(clock_pin_oe_o, m < 4 && !v[5]);
        chk(clock_pin_o ^ bus_clk_lvl_i, 1'b1);
        $display("change mode %0d value %h done", m, v);
    endtask

    initial begin
        logic [7:0] w;
        seed = 32'hf6f3;
        err_count = 0;
        check_count = 0;
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {clock_mode_pins_i, clock_pin_i, bus_clk_lvl_i, cache_read_i, ext_write_i} = '0;
        {watchdog_timer_mode_i, watchdog_count_enable_i, dma_busy_i, watchdog_overflow_i} = '0;
        // reset value and write masking in every mode
        for (int m = 0; m < 7; m++) begin
            rst(m);
            apb(1'b0, `CFC_CTRL_ADDR, 32'h0);
            chk(rdv, rstv(m));
            repeat (3) begin
                w = 8'($random(seed));
                w[4] = 1'b0;
                w[5] = w[5] & w[6];
                w[3:0] = legal(m, w);
                apb(1'b1, `CFC_CTRL_ADDR, {24'h0, w});
                #1;
                chk(watchdog_start_o, 1'b0);
                apb(1'b0, `CFC_CTRL_ADDR, 32'h0);
                chk(rdv, fixv(m, w));
            end
            $display("mode %0d register test done", m);
        end
        // unmapped address answers with an error and zero data
        apb(1'b0, 32'hFFFFFE98, 32'h0);
        chk({erv, rdv[7:0]}, 9'h100);
        // each broken preparation keeps the watchdog idle
        rst(0);
        for (int k = 0; k < 5; k++) begin
            if (k > 0) arm();
            ext_write_i <= (k == 1);
            dma_busy_i <= (k == 2);
            watchdog_timer_mode_i <= (k == 3);
            watchdog_count_enable_i <= (k == 4);
            apb(1'b1, `CFC_CTRL_ADDR, 32'h0A);
            {ext_write_i, dma_busy_i, watchdog_timer_mode_i, watchdog_count_enable_i} <= 4'h0;
            #1;
            chk({watchdog_start_o, clocks_stop_o}, 2'b00);
        end
        // status: last write unprepared, not armed, not settling; pin bit ignored
        apb(1'b0, `CFC_STAT_ADDR, 32'h0);
        chk(rdv & 32'hFFFFFF7F, 32'h00000004);
        $display("preparation test done");
        settle(0, 8'h0A, {5'h10, 5'h10, 5'h08, 5'h08});
        settle(0, 8'h45, {5'h08, 5'h08, 5'h08, 5'h04});
        settle(0, 8'h88, {5'h10, 5'h10, 5'h04, 5'h04});
        settle(4, 8'hA9, {5'h08, 5'h08, 5'h04, 5'h02});
        settle(6, 8'hEF, {5'h04, 5'h04, 5'h04, 5'h04});
        settle(2, 8'hD4, {5'h04, 5'h02, 5'h01, 5'h01});
        settle(0, 8'h03, 20'h0);
        results();
    end
endmodule
